//--- hw/iwc_pkg.sv
// Shared constants for the instruction fetch watchpoint control block
package iwc_pkg;

  // Special-purpose register number of the control word
  localparam logic [9:0]  FETCH_WATCH_CONTROL_REG = 10'h09e;
  localparam logic [31:0] SOFT_RESET_VALUE        = 32'h0000_0000;

  // Field positions as word bit indices; field bit 0 is the word's MSB
  localparam int CMP_A_TYPE_LSB  = 29;
  localparam int CMP_B_TYPE_LSB  = 26;
  localparam int CMP_C_TYPE_LSB  = 23;
  localparam int CMP_D_TYPE_LSB  = 20;
  localparam int CMP_TYPE_W      = 3;
  localparam int WATCH_FIRST_LSB = 18;
  localparam int WATCH_SECOND_LSB = 16;
  localparam int WATCH_THIRD_LSB = 14;
  localparam int WATCH_FOURTH_LSB = 12;
  localparam int WATCH_SEL_W     = 2;
  localparam int SHOW_CYCLE_LSB  = 0;
  localparam int SHOW_CYCLE_W    = 2;

  // Relation held in the two low bits of a compare type
  typedef enum logic [1:0] {
    IWC_REL_EQ = 2'b00,
    IWC_REL_LT = 2'b01,
    IWC_REL_GT = 2'b10,
    IWC_REL_NE = 2'b11
  } iwc_rel_t;

  // Watchpoint select codes; 0x disables the watchpoint
  localparam logic [1:0] WATCH_SEL_SINGLE = 2'b10;
  localparam logic [1:0] WATCH_SEL_PAIR   = 2'b11;

  // Instructions completed after the write before a new show setting applies
  localparam logic [1:0] SHOW_DELAY_INSTR = 2'h1;

endpackage : iwc_pkg

//--- hw/iwc_comparator.sv
// One fetch address comparator with mode dependent type decoding
`timescale 1ns/100ps

module iwc_comparator #(
  parameter int ADDR_W = 32
) (
  input  wire logic [2:0]        cmpType,
  input  wire logic              compressedMode,
  input  wire logic [ADDR_W-1:0] fetchAddr,
  input  wire logic [ADDR_W-1:0] refAddr,
  output logic                   cmpActive,
  output logic                   cmpHit
);

  iwc_pkg::iwc_rel_t relation;
  logic              relTrue;

  // Top bit must differ from the code mode to be active
  assign cmpActive = cmpType[2] ^ compressedMode;
  assign relation  = iwc_pkg::iwc_rel_t'(cmpType[1:0]);

  // Relation against the fetched address, unsigned
  always_comb begin
    relTrue = 1'b0;
    unique case (relation)
      iwc_pkg::IWC_REL_EQ: relTrue = (fetchAddr == refAddr);
      iwc_pkg::IWC_REL_LT: relTrue = (fetchAddr <  refAddr);
      iwc_pkg::IWC_REL_GT: relTrue = (fetchAddr >  refAddr);
      iwc_pkg::IWC_REL_NE: relTrue = (fetchAddr != refAddr);
    endcase
  end

  assign cmpHit = cmpActive & relTrue;

endmodule // iwc_comparator

//--- hw/iwc_watch_control.sv
// Fetch watchpoint control word, comparators and watchpoint combining
`timescale 1ns/100ps

// Function
// - Four three-bit compare type fields A to D
// - Non-compressed: top bit zero means inactive
// - Compressed: top bit one means inactive
// - Reset clears all compare type fields
// - First watchpoint: A, or A and B
// - Second watchpoint: B, or A or B
// - Third watchpoint: C, or C and D
// - Fourth watchpoint: D, or C or D
// - Show setting applies from second instruction
// - Aborted branch fetch may hide pins only
module iwc_watch_control #(
  parameter int ADDR_W = 32,
  parameter int NUM_CMP = 4
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              sprWriteEn,
  input  wire logic              sprReadEn,
  input  wire logic [9:0]        sprAddr,
  input  wire logic [31:0]       sprWriteData,
  input  wire logic              instrDone,
  input  wire logic              compressedMode,
  input  wire logic              fetchValid,
  input  wire logic              fetchAbort,
  input  wire logic [ADDR_W-1:0] fetchAddr,
  input  wire logic [ADDR_W-1:0] cmpARef,
  input  wire logic [ADDR_W-1:0] cmpBRef,
  input  wire logic [ADDR_W-1:0] cmpCRef,
  input  wire logic [ADDR_W-1:0] cmpDRef,
  output logic [31:0]            sprReadData,
  output logic                   sprReadAck,
  output logic [NUM_CMP-1:0]     cmpMatch,
  output logic [3:0]             watchHit,
  output logic [1:0]             showCycleSetting,
  output logic                   traceFetchValid,
  output logic [ADDR_W-1:0]      traceFetchAddr,
  output logic                   pinShowValid
);

  // Control word as written by software
  logic [31:0]               fetchWatchControlReg;
  logic [2:0]                cmpType [NUM_CMP];
  logic [ADDR_W-1:0]         cmpRef  [NUM_CMP];
  logic [NUM_CMP-1:0]        cmpRaw;
  logic [NUM_CMP-1:0]        cmpActive;
  logic [1:0]                watchSel [4];
  logic [3:0]                next_watchHit;
  logic                      regHit;
  logic                      writeHit;
  logic                      readHit;
  logic                      showPending;
  logic [1:0]                pendingShow;
  logic [1:0]                showCount;

  // Single register decode shared by reads and writes
  function automatic logic spr_select(input logic [9:0] addr);
    return addr == iwc_pkg::FETCH_WATCH_CONTROL_REG;
  endfunction

  // Watchpoint select: single comparator, or pair joined by and/or
  function automatic logic watch_decode(input logic [1:0] sel,
                                        input logic       single,
                                        input logic       first,
                                        input logic       second,
                                        input logic       useAnd);
    logic pair;
    pair = useAnd ? (first & second) : (first | second);
    unique case (sel)
      iwc_pkg::WATCH_SEL_SINGLE: return single;
      iwc_pkg::WATCH_SEL_PAIR:   return pair;
      default:                   return 1'b0;
    endcase
  endfunction

  assign regHit   = spr_select(sprAddr);
  assign writeHit = sprWriteEn & regHit;
  assign readHit  = sprReadEn & spr_select(sprAddr);

  // Whole word stored as written, cleared by reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fetchWatchControlReg <= iwc_pkg::SOFT_RESET_VALUE;
    end else if (writeHit) begin
      fetchWatchControlReg <= sprWriteData;
    end
  end

  // Read port answers one cycle later; other numbers read as zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sprReadData <= 32'h0000_0000;
      sprReadAck  <= 1'b0;
    end else begin
      sprReadAck  <= readHit;
      sprReadData <= readHit ? fetchWatchControlReg : 32'h0000_0000;
    end
  end

  // Type fields sliced from their bit positions
  assign cmpType[0] = fetchWatchControlReg[iwc_pkg::CMP_A_TYPE_LSB +: iwc_pkg::CMP_TYPE_W];
  assign cmpType[1] = fetchWatchControlReg[iwc_pkg::CMP_B_TYPE_LSB +: iwc_pkg::CMP_TYPE_W];
  assign cmpType[2] = fetchWatchControlReg[iwc_pkg::CMP_C_TYPE_LSB +: iwc_pkg::CMP_TYPE_W];
  assign cmpType[3] = fetchWatchControlReg[iwc_pkg::CMP_D_TYPE_LSB +: iwc_pkg::CMP_TYPE_W];

  // Watchpoint select fields
  assign watchSel[0] = fetchWatchControlReg[iwc_pkg::WATCH_FIRST_LSB +: iwc_pkg::WATCH_SEL_W];
  assign watchSel[1] = fetchWatchControlReg[iwc_pkg::WATCH_SECOND_LSB +: iwc_pkg::WATCH_SEL_W];
  assign watchSel[2] = fetchWatchControlReg[iwc_pkg::WATCH_THIRD_LSB +: iwc_pkg::WATCH_SEL_W];
  assign watchSel[3] = fetchWatchControlReg[iwc_pkg::WATCH_FOURTH_LSB +: iwc_pkg::WATCH_SEL_W];

  // Reference addresses arrive on ports, outside this word
  assign cmpRef[0] = cmpARef;
  assign cmpRef[1] = cmpBRef;
  assign cmpRef[2] = cmpCRef;
  assign cmpRef[3] = cmpDRef;

  // One comparator per reference, gated by a valid fetch
  for (genvar i = 0; i < NUM_CMP; i++) begin : gCmp
    logic hit;
    iwc_comparator #(
      .ADDR_W         (ADDR_W)
    ) uCmp (
      .cmpType        (cmpType[i]),
      .compressedMode (compressedMode),
      .fetchAddr      (fetchAddr),
      .refAddr        (cmpRef[i]),
      .cmpActive      (cmpActive[i]),
      .cmpHit         (hit)
    );
    assign cmpRaw[i] = hit & fetchValid;
  end

  always_comb begin
    next_watchHit[0] = watch_decode(watchSel[0], cmpRaw[0], cmpRaw[0], cmpRaw[1], 1'b1);
    next_watchHit[1] = watch_decode(watchSel[1], cmpRaw[1], cmpRaw[0], cmpRaw[1], 1'b0);
    next_watchHit[2] = watch_decode(watchSel[2], cmpRaw[2], cmpRaw[2], cmpRaw[3], 1'b1);
    next_watchHit[3] = watch_decode(watchSel[3], cmpRaw[3], cmpRaw[2], cmpRaw[3], 1'b0);
  end

  // Per-fetch match outputs, registered to break the compare path
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmpMatch <= '0;
      watchHit <= 4'h0;
    end else begin
      cmpMatch <= cmpRaw;
      watchHit <= next_watchHit;
    end
  end

  // Hold a changed show setting until one instruction retires
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      showPending <= 1'b0;
      pendingShow <= 2'h0;
      showCount   <= 2'h0;
    end else if (writeHit) begin
      // A later write restarts the delay; retire in this cycle is the write itself
      showPending <= 1'b1;
      pendingShow <= sprWriteData[iwc_pkg::SHOW_CYCLE_LSB +: iwc_pkg::SHOW_CYCLE_W];
      showCount   <= iwc_pkg::SHOW_DELAY_INSTR;
    end else if (showPending && instrDone) begin
      showCount   <= showCount - 2'h1;
      showPending <= (showCount != 2'h1);
    end
  end

  // Effective setting changes only after the delay
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      showCycleSetting <= 2'h0;
    end else if (showPending && instrDone && !writeHit && showCount == 2'h1) begin
      showCycleSetting <= pendingShow;
    end
  end

  // Trace sees every fetch; pins may miss an aborted one
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      traceFetchValid <= 1'b0;
      traceFetchAddr  <= '0;
      pinShowValid    <= 1'b0;
    end else begin
      traceFetchValid <= fetchValid;
      traceFetchAddr  <= fetchAddr;
      pinShowValid    <= fetchValid & ~fetchAbort & (showCycleSetting != 2'h0);
    end
  end

  // Checks on the driven behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_WRITE_STORED: assert property (writeHit |=>
    fetchWatchControlReg == $past(sprWriteData))
    else $error("control word did not take the write");

  AST_READ_BACK: assert property (readHit && !writeHit |=> sprReadAck &&
    sprReadData == fetchWatchControlReg)
    else $error("read did not return the stored word");

  AST_AFTER_RESET: assert property ($fell(sys_rst) |-> cmpType[0] == 3'h0 &&
    cmpType[1] == 3'h0 && cmpType[2] == 3'h0 && cmpType[3] == 3'h0)
    else $error("type fields not zero after reset");

  AST_NONCOMP_IDLE: assert property (!compressedMode && !cmpType[0][2] |=> !cmpMatch[0])
    else $error("comparator A matched while inactive");

  AST_COMP_IDLE: assert property (compressedMode && cmpType[1][2] |=> !cmpMatch[1])
    else $error("comparator B matched while inactive in compressed mode");

  AST_EQ_MATCH: assert property (fetchValid && !compressedMode &&
    cmpType[2] == 3'b100 && fetchAddr == cmpCRef |=> cmpMatch[2])
    else $error("equal compare missed a match");

  AST_COMP_EQ_MATCH: assert property (fetchValid && compressedMode &&
    cmpType[3] == 3'b000 && fetchAddr == cmpDRef |=> cmpMatch[3])
    else $error("compressed equal compare missed a match");

  AST_LT_MATCH: assert property (fetchValid && !compressedMode &&
    cmpType[1] == 3'b101 && fetchAddr < cmpBRef |=> cmpMatch[1])
    else $error("less than compare missed a match");

  AST_IDLE_SILENT: assert property (!cmpActive[1] |=> !cmpMatch[1])
    else $error("inactive comparator B reported a match");

  AST_NO_FETCH: assert property (!fetchValid |=> cmpMatch == '0 && watchHit == 4'h0)
    else $error("match reported without a fetch");

  AST_FIRST_OFF: assert property (!watchSel[0][1] |=> !watchHit[0])
    else $error("first watchpoint fired while disabled");

  AST_FIRST_SINGLE: assert property (watchSel[0] == 2'b10 |=>
    watchHit[0] == $past(cmpRaw[0]))
    else $error("first watchpoint single wrong");

  AST_FIRST_AND: assert property (watchSel[0] == 2'b11 |=>
    watchHit[0] == ($past(cmpRaw[0]) & $past(cmpRaw[1])))
    else $error("first watchpoint pair wrong");

  AST_SECOND_SINGLE: assert property (watchSel[1] == 2'b10 |=>
    watchHit[1] == $past(cmpRaw[1]))
    else $error("second watchpoint single wrong");

  AST_SECOND_OR: assert property (watchSel[1] == 2'b11 |=>
    watchHit[1] == ($past(cmpRaw[0]) | $past(cmpRaw[1])))
    else $error("second watchpoint pair wrong");

  AST_THIRD_SINGLE: assert property (watchSel[2] == 2'b10 |=>
    watchHit[2] == $past(cmpRaw[2]))
    else $error("third watchpoint single wrong");

  AST_THIRD_AND: assert property (watchSel[2] == 2'b11 |=>
    watchHit[2] == ($past(cmpRaw[2]) & $past(cmpRaw[3])))
    else $error("third watchpoint pair wrong");

  AST_FOURTH_OFF: assert property (!watchSel[3][1] |=> !watchHit[3])
    else $error("fourth watchpoint fired while disabled");

  AST_FOURTH_OR: assert property (watchSel[3] == 2'b11 |=>
    watchHit[3] == ($past(cmpRaw[2]) | $past(cmpRaw[3])))
    else $error("fourth watchpoint pair wrong");

  AST_SHOW_HOLD: assert property (writeHit |=>
    showCycleSetting == $past(showCycleSetting))
    else $error("show setting changed at the write");

  AST_SHOW_WAIT: assert property (!instrDone && !writeHit |=> $stable(showCycleSetting))
    else $error("show setting changed without a retired instruction");

  AST_SHOW_APPLY: assert property (showPending && instrDone && !writeHit |=>
    showCycleSetting == $past(pendingShow))
    else $error("show setting not applied after one instruction");

  AST_ABORT_PINS: assert property (fetchValid && fetchAbort |=> !pinShowValid &&
    traceFetchValid)
    else $error("aborted fetch handling wrong");

  AST_TRACE_COPY: assert property (fetchValid |=> traceFetchValid &&
    traceFetchAddr == $past(fetchAddr))
    else $error("trace lost a fetched address");

  // Main scenarios reached
  COV_PAIR_HIT: cover property (watchSel[0] == 2'b11 ##1 watchHit[0]);
  COV_COMP_MODE: cover property (compressedMode && cmpType[0] == 3'b000 ##1 cmpMatch[0]);
  COV_SHOW_CHANGE: cover property (writeHit ##[1:8] $changed(showCycleSetting));
  COV_ABORT: cover property (fetchValid && fetchAbort);

endmodule // iwc_watch_control

//--- tb/iwc_watch_control_tb.sv
// Self-checking bench for the fetch watchpoint control block
`timescale 1ns/100ps

module iwc_watch_control_tb;
  localparam logic [9:0]  CTRL  = iwc_pkg::FETCH_WATCH_CONTROL_REG;
  localparam logic [31:0] REF_A = 32'h0000_0100;
  localparam logic [31:0] REF_B = 32'h0000_0200;
  localparam logic [31:0] REF_C = 32'h0000_0300;
  localparam logic [31:0] REF_D = 32'h0000_0400;

  logic        core_clk       = 1'b0;
  logic        sys_rst        = 1'b1;
  logic        sprWriteEn     = 1'b0;
  logic        sprReadEn      = 1'b0;
  logic [9:0]  sprAddr        = 10'h000;
  logic [31:0] sprWriteData   = 32'h0;
  logic        instrDone      = 1'b0;
  logic        compressedMode = 1'b0;
  logic        fetchValid     = 1'b0;
  logic        fetchAbort     = 1'b0;
  logic [31:0] fetchAddr      = 32'h0;
  logic [31:0] sprReadData;
  logic [31:0] traceFetchAddr;
  logic        sprReadAck;
  logic        traceFetchValid;
  logic        pinShowValid;
  logic [3:0]  cmpMatch;
  logic [3:0]  watchHit;
  logic [1:0]  showCycleSetting;
  logic [31:0] adrs [5]       = '{32'h50, 32'h100, 32'h200, 32'h300, 32'h400};
  int          fail_count     = 0;
  int          checks_done    = 0;
  int          cycles         = 0;

  iwc_watch_control i_iwc_watch_control (
    .core_clk(core_clk), .sys_rst(sys_rst), .sprWriteEn(sprWriteEn),
    .sprReadEn(sprReadEn), .sprAddr(sprAddr), .sprWriteData(sprWriteData),
    .instrDone(instrDone), .compressedMode(compressedMode),
    .fetchValid(fetchValid), .fetchAbort(fetchAbort), .fetchAddr(fetchAddr),
    .cmpARef(REF_A), .cmpBRef(REF_B), .cmpCRef(REF_C), .cmpDRef(REF_D),
    .sprReadData(sprReadData), .sprReadAck(sprReadAck), .cmpMatch(cmpMatch),
    .watchHit(watchHit), .showCycleSetting(showCycleSetting),
    .traceFetchValid(traceFetchValid), .traceFetchAddr(traceFetchAddr),
    .pinShowValid(pinShowValid)
  );

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // Hang guard, run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("mismatches %0d, checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Write strobe held one cycle; retire pulse may share the write cycle
  task automatic wr(logic [9:0] a, logic [31:0] d, logic done);
    @(negedge core_clk);
    sprWriteEn = 1'b1;
    sprAddr = a;
    sprWriteData = d;
    instrDone = done;
    @(negedge core_clk);
    sprWriteEn = 1'b0;
    instrDone = 1'b0;
  endtask

  // Answer is registered, so it is looked at one cycle later
  task automatic rd(logic [9:0] a, logic ack, logic [31:0] d);
    @(negedge core_clk);
    sprReadEn = 1'b1;
    sprAddr = a;
    @(negedge core_clk);
    sprReadEn = 1'b0;
    chk("read ack", {31'h0, ack}, {31'h0, sprReadAck});
    chk("read data", d, sprReadData);
  endtask

  task automatic fch(logic [31:0] a, logic ab);
    @(negedge core_clk);
    fetchValid = 1'b1;
    fetchAddr = a;
    fetchAbort = ab;
    @(negedge core_clk);
    fetchValid = 1'b0;
    fetchAbort = 1'b0;
  endtask

  // Reference relation: fetch address against comparator reference
  function automatic logic hit(logic [2:0] t, logic m, logic [31:0] f, logic [31:0] r);
    if (t[2] == m) return 1'b0;
    case (t[1:0])
      2'b00:   return f == r;
      2'b01:   return f < r;
      2'b10:   return f > r;
      default: return f != r;
    endcase
  endfunction

  function automatic logic [3:0] wexp(logic [1:0] s, logic [3:0] c);
    wexp[0] = s[1] & (s[0] ? c[0] & c[1] : c[0]);
    wexp[1] = s[1] & (s[0] ? c[0] | c[1] : c[1]);
    wexp[2] = s[1] & (s[0] ? c[2] & c[3] : c[2]);
    wexp[3] = s[1] & (s[0] ? c[2] | c[3] : c[3]);
  endfunction

  initial begin
    logic [31:0] w;
    logic [3:0]  em;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(CTRL, 1'b1, 32'h0);
    // Show setting waits for a retire after the write cycle
    wr(CTRL, 32'h0000_0003, 1'b1);
    chk("show", 32'h0, showCycleSetting);
    repeat (2) @(negedge core_clk);
    chk("show", 32'h0, showCycleSetting);
    instrDone = 1'b1;
    @(negedge core_clk);
    instrDone = 1'b0;
    chk("show", 32'h3, showCycleSetting);
    // Aborted fetch still traced, but hidden from the pins
    fch(REF_A, 1'b1);
    chk("trace valid", 32'h1, traceFetchValid);
    chk("pin show", 32'h0, pinShowValid);
    fch(REF_A, 1'b0);
    chk("pin show", 32'h1, pinShowValid);
    // Other register numbers leave the word alone
    wr(10'h09f, 32'hffff_ffff, 1'b0);
    rd(CTRL, 1'b1, 32'h0000_0003);
    rd(10'h09f, 1'b0, 32'h0);
    // Every type and select code, both modes; field numbering starts at the MSB
    for (int t = 0; t < 8; t++) begin
      w = {{4{t[2:0]}}, {4{t[1:0]}}, 10'h2b5, t[1:0]};
      wr(CTRL, w, 1'b0);
      rd(CTRL, 1'b1, w);
      for (int m = 0; m < 2; m++) begin
        compressedMode = m[0];
        foreach (adrs[k]) begin
          fch(adrs[k], 1'b0);
          em = {hit(t[2:0], m[0], adrs[k], REF_D), hit(t[2:0], m[0], adrs[k], REF_C),
                hit(t[2:0], m[0], adrs[k], REF_B), hit(t[2:0], m[0], adrs[k], REF_A)};
          chk("match", {28'h0, em}, {28'h0, cmpMatch});
          chk("watch", {28'h0, wexp(t[1:0], em)}, {28'h0, watchHit});
          chk("trace addr", adrs[k], traceFetchAddr);
        end
      end
    end
    // Second reset in mid-run: compressed mode compares for equality
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    compressedMode = 1'b1;
    fch(REF_A, 1'b0);
    chk("match", 32'h1, {28'h0, cmpMatch});
    chk("watch", 32'h0, {28'h0, watchHit});
    chk("show", 32'h0, showCycleSetting);
    rd(CTRL, 1'b1, 32'h0);
    give_verdict();
  end
endmodule // iwc_watch_control_tb
